// ---- verilog/nvm_protection_regs.svh ----
// Purpose : offsets, field positions, blank values and decode constants of the
//           protection configuration words
// Assumes : included by bare name; definitions only
// Notes   : the blank (erased) state of every configuration bit is 1
`ifndef NVM_PROTECTION_REGS_SVH
`define NVM_PROTECTION_REGS_SVH

// configuration word addresses in the configuration space
`define CFG_ADDR_W          22
`define CFG_WORD_LOW_ADDR   22'h300006
`define CFG_WORD_HIGH_ADDR  22'h300007

// low word field positions
`define LOW_APP_WP_BIT      7
`define LOW_SA_EN_BIT       4
`define LOW_BB_EN_BIT       3
`define LOW_BB_SIZE_HI      2
`define LOW_BB_SIZE_LO      0

// high word field positions
`define HIGH_LV_PROG_BIT    5
`define HIGH_SA_WP_BIT      3
`define HIGH_EE_WP_BIT      2
`define HIGH_CFG_WP_BIT     1
`define HIGH_BB_WP_BIT      0

// blank values and the bits that always read as 1
`define CFG_BLANK_BYTE      8'hFF
`define LOW_UNIMPL_MASK     8'h60
`define HIGH_UNIMPL_MASK    8'hD0
`define UNMAPPED_READ       8'hFF

// boot block size decode: code 111 is 2^9 words, each lower code doubles down to 001; 000 equals 001
`define BB_SIZE_MAX_CODE    3'h7
`define BB_MIN_LOG2         5'h09
`define BB_TOP_LOG2         5'h0F
`define BB_WORDS_W          16
`define PROG_WORDS_LOG2_DEF 15

`endif

// ---- verilog/nvm_protection_pkg.sv ----
// Purpose : types and shared decoding for the protection configuration words
// Assumes : nvm_protection_regs.svh supplies the addresses
// Notes   : word select encoding is gray along none -> low -> high
`default_nettype none
`include "nvm_protection_regs.svh"

package nvm_protection_pkg;

    // which configuration word an access targets
    typedef enum logic [1:0] {
        CFG_NONE = 2'h0,
        CFG_LOW  = 2'h1,
        CFG_HIGH = 2'h3
    } cfg_sel_t;

    typedef logic [`CFG_ADDR_W-1:0] cfg_addr_t;
    typedef logic [7:0]             cfg_byte_t;

    // address decode shared by the write and read paths
    function automatic cfg_sel_t decode_cfg_addr(input cfg_addr_t addr);
        cfg_sel_t sel;
        sel = CFG_NONE;
        if (addr == `CFG_WORD_LOW_ADDR) begin
            sel = CFG_LOW;
        end else if (addr == `CFG_WORD_HIGH_ADDR) begin
            sel = CFG_HIGH;
        end
        return sel;
    endfunction : decode_cfg_addr

endpackage : nvm_protection_pkg
`default_nettype wire

// ---- verilog/boot_block_decode.sv ----
// Purpose : turn the boot block enable and size code into a word count
// Assumes : combinational; caller registers the results
// Notes   : size is clipped to half of user program memory
`timescale 1ns/1ps
`default_nettype none
`include "nvm_protection_regs.svh"

module boot_block_decode #(
    parameter int PROG_WORDS_LOG2 = `PROG_WORDS_LOG2_DEF  // log2 of user program words
) (
    input  wire logic                     enable_n,     // 0 = boot block present
    input  wire logic [2:0]               size_sel,     // raw size code
    output logic      [`BB_WORDS_W-1:0]   words,        // decoded size, 0 if absent
    output logic      [`BB_WORDS_W-1:0]   last_addr     // last word address of block
);
    import nvm_protection_pkg::*;

    // half of program memory, as a log2 of words
    localparam logic [4:0] HALF_LOG2 = 5'(PROG_WORDS_LOG2 - 1);

    logic [4:0] code_log2;   // log2 selected by the code alone
    logic [4:0] eff_log2;    // after the half-memory clip

    // each step down in code doubles the block; 001 and 000 both top out
    always_comb begin
        if (size_sel <= 3'h1) begin
            code_log2 = `BB_TOP_LOG2;
        end else begin
            code_log2 = `BB_MIN_LOG2 + 5'(`BB_SIZE_MAX_CODE - size_sel);
        end
        eff_log2 = (code_log2 > HALF_LOG2) ? HALF_LOG2 : code_log2;
    end

    // absent block decodes to zero words regardless of the code
    always_comb begin
        if (enable_n) begin
            words     = '0;
            last_addr = '0;
        end else begin
            words     = `BB_WORDS_W'(1) << eff_log2;
            last_addr = words - `BB_WORDS_W'(1);
        end
    end

endmodule : boot_block_decode
`default_nettype wire

// ---- verilog/nvm_protection_config.sv ----
// Purpose : non-volatile protection configuration words: storage, sticky
//           write behaviour, bulk erase and decoded protection outputs
// Assumes : programming controller drives the access port on clk; single clock
// Notes   : outputs are all registered and so lag a write by one cycle
//
// Notes on behaviour
// - protection bits only clear; erase restores them
// - size code frozen once boot block enabled
// - enable low; disabled block decodes zero size
// - code 111 512 words, doubling, 001/000 32768
// - boot block clipped to half program memory
// - storage area enable bit is active low
// - write protect bits active low per region
// - storage area protect absent or needs enable
// - eeprom protect unimplemented without data eeprom
// - boot protect applies only with boot block
// - low voltage bit 1 forces reset pin function
// - low voltage bit not clearable from LV interface
// - unimplemented bits read back as ones
`timescale 1ns/1ps
`default_nettype none
`include "nvm_protection_regs.svh"

module nvm_protection_config #(
    parameter int PROG_WORDS_LOG2  = `PROG_WORDS_LOG2_DEF, // log2 of user program words
    parameter bit HAS_STORAGE_AREA = 1'b1,                 // storage area flash fitted
    parameter bit HAS_EEPROM       = 1'b1                  // data eeprom fitted
) (
    input  wire logic                          clk,
    input  wire logic                          srst,
    // configuration access port
    input  wire logic                          cfg_wr,          // write strobe
    input  wire logic                          cfg_rd,          // read strobe
    input  wire nvm_protection_pkg::cfg_addr_t cfg_addr,        // word address
    input  wire nvm_protection_pkg::cfg_byte_t cfg_wdata,       // write data
    input  wire logic                          cfg_self_write,  // access from firmware
    input  wire logic                          bulk_erase,      // erase pulse
    input  wire logic                          lv_prog_active,  // LV interface in use
    input  wire logic                          reset_pin_enable,// reset pin setting
    output nvm_protection_pkg::cfg_byte_t      cfg_rdata,       // read data
    output logic                               cfg_rvalid,      // read data valid
    output logic                               cfg_wr_refused,  // write blocked
    // decoded protection state
    output logic                               boot_block_enable_n,
    output logic [2:0]                         boot_block_size_sel,
    output logic [`BB_WORDS_W-1:0]             boot_block_words,
    output logic [`BB_WORDS_W-1:0]             boot_block_last_addr,
    output logic                               storage_area_enable_n,
    output logic                               app_block_write_protect_n,
    output logic                               storage_area_write_protect_n,
    output logic                               eeprom_write_protect_n,
    output logic                               config_write_protect_n,
    output logic                               boot_block_write_protect_n,
    output logic                               low_volt_prog_enable,
    output logic                               reset_pin_active
);
    import nvm_protection_pkg::*;

    // stored configuration bits, blank = 1
    logic       app_wp_n;      // application block protect
    logic       sa_en_n;       // storage area enable
    logic       bb_en_n;       // boot block enable
    logic [2:0] bb_size;       // boot block size code
    logic       lv_prog_en;    // low voltage programming enable
    logic       sa_wp_n;       // storage area protect
    logic       ee_wp_n;       // eeprom protect
    logic       cfg_wp_n;      // configuration protect
    logic       bb_wp_n;       // boot block protect

    cfg_sel_t   wr_sel;        // word targeted by a write
    cfg_sel_t   rd_sel;        // word targeted by a read
    logic       wr_locked;     // firmware write into protected config space
    logic       lv_clear_try;  // attempt to drop low voltage mode from LV
    logic       wr_low;        // accepted write of the low word
    logic       wr_high;       // accepted write of the high word

    logic [`BB_WORDS_W-1:0] dec_words;  // decoded boot block size
    logic [`BB_WORDS_W-1:0] dec_last;   // decoded last address

    // a configuration protect only guards against firmware self-writes;
    // an external programmer is expected to erase first instead
    always_comb begin
        wr_sel        = decode_cfg_addr(cfg_addr);
        rd_sel        = decode_cfg_addr(cfg_addr);
        wr_locked     = cfg_self_write && !cfg_wp_n;
        lv_clear_try  = (wr_sel == CFG_HIGH) && lv_prog_active
                        && !cfg_wdata[`HIGH_LV_PROG_BIT];
        wr_low        = cfg_wr && !bulk_erase && !wr_locked && (wr_sel == CFG_LOW);
        wr_high       = cfg_wr && !bulk_erase && !wr_locked && (wr_sel == CFG_HIGH);
    end

    // low word: protection bits can only go from 1 to 0; erase wins over a write
    always_ff @(posedge clk) begin
        if (srst || bulk_erase) begin
            app_wp_n <= 1'b1;
            sa_en_n  <= 1'b1;
            bb_en_n  <= 1'b1;
            bb_size  <= 3'h7;
        end else if (wr_low) begin
            app_wp_n <= app_wp_n & cfg_wdata[`LOW_APP_WP_BIT];
            sa_en_n  <= sa_en_n & cfg_wdata[`LOW_SA_EN_BIT];
            bb_en_n  <= bb_en_n  & cfg_wdata[`LOW_BB_EN_BIT];
            // size follows the write only while the block is still disabled
            if (bb_en_n) begin
                bb_size <= cfg_wdata[`LOW_BB_SIZE_HI:`LOW_BB_SIZE_LO];
            end
        end
    end

    // high word: same sticky behaviour, with variant-absent bits held at 1
    always_ff @(posedge clk) begin
        if (srst || bulk_erase) begin
            lv_prog_en <= 1'b1;
            sa_wp_n  <= 1'b1;
            ee_wp_n  <= 1'b1;
            cfg_wp_n <= 1'b1;
            bb_wp_n  <= 1'b1;
        end else if (wr_high) begin
            // LV interface may never clear its own enable
            if (!lv_clear_try) begin
                lv_prog_en <= lv_prog_en & cfg_wdata[`HIGH_LV_PROG_BIT];
            end
            sa_wp_n  <= HAS_STORAGE_AREA ? (sa_wp_n & cfg_wdata[`HIGH_SA_WP_BIT])
                                         : 1'b1;
            ee_wp_n  <= HAS_EEPROM ? (ee_wp_n & cfg_wdata[`HIGH_EE_WP_BIT])
                                   : 1'b1;
            cfg_wp_n <= cfg_wp_n & cfg_wdata[`HIGH_CFG_WP_BIT];
            bb_wp_n  <= bb_wp_n  & cfg_wdata[`HIGH_BB_WP_BIT];
        end
    end

    // refused writes: locked config space or a blocked LV clear
    always_ff @(posedge clk) begin
        if (srst) begin
            cfg_wr_refused <= 1'b0;
        end else begin
            cfg_wr_refused <= cfg_wr && !bulk_erase && (wr_sel != CFG_NONE)
                              && (wr_locked || lv_clear_try);
        end
    end

    // read path: one cycle latency, unimplemented bits forced to 1
    always_ff @(posedge clk) begin
        if (srst) begin
            cfg_rdata  <= `UNMAPPED_READ;
            cfg_rvalid <= 1'b0;
        end else begin
            cfg_rvalid <= cfg_rd;
            // data moves only on a read, so a slow reader can still take it
            if (cfg_rd) begin
                case (rd_sel)
                    CFG_LOW: begin
                        cfg_rdata <= `LOW_UNIMPL_MASK
                                     | {app_wp_n, 2'h0, sa_en_n, bb_en_n, bb_size};
                    end
                    CFG_HIGH: begin
                        cfg_rdata <= `HIGH_UNIMPL_MASK
                                     | {2'h0, lv_prog_en, 1'b0, sa_wp_n, ee_wp_n,
                                        cfg_wp_n, bb_wp_n};
                    end
                    default: begin
                        cfg_rdata <= `UNMAPPED_READ;  // unmapped reads like blank
                    end
                endcase
            end
        end
    end

    // boot block size decode lives apart so its table stays readable
    boot_block_decode #(
        .PROG_WORDS_LOG2 (PROG_WORDS_LOG2)
    ) u_bb_decode (
        .enable_n  (bb_en_n),
        .size_sel  (bb_size),
        .words     (dec_words),
        .last_addr (dec_last)
    );

    // boot block outputs, registered from the decode
    always_ff @(posedge clk) begin
        if (srst) begin
            boot_block_enable_n  <= 1'b1;
            boot_block_size_sel  <= 3'h7;
            boot_block_words     <= '0;
            boot_block_last_addr <= '0;
        end else begin
            boot_block_enable_n  <= bb_en_n;
            boot_block_size_sel  <= bb_size;
            boot_block_words     <= dec_words;
            boot_block_last_addr <= dec_last;
        end
    end

    // effective region protections; a bit with no region behind it reads
    // back as stored but never protects anything
    always_ff @(posedge clk) begin
        if (srst) begin
            storage_area_enable_n        <= 1'b1;
            app_block_write_protect_n    <= 1'b1;
            storage_area_write_protect_n <= 1'b1;
            eeprom_write_protect_n       <= 1'b1;
            config_write_protect_n       <= 1'b1;
            boot_block_write_protect_n   <= 1'b1;
        end else begin
            storage_area_enable_n        <= HAS_STORAGE_AREA ? sa_en_n : 1'b1;
            app_block_write_protect_n    <= app_wp_n;
            storage_area_write_protect_n <= sa_wp_n | sa_en_n
                                            | !HAS_STORAGE_AREA;
            eeprom_write_protect_n       <= ee_wp_n | !HAS_EEPROM;
            config_write_protect_n       <= cfg_wp_n;
            boot_block_write_protect_n   <= bb_wp_n | bb_en_n;
        end
    end

    // pin function: LV enable overrides the reset pin setting
    always_ff @(posedge clk) begin
        if (srst) begin
            low_volt_prog_enable <= 1'b1;
            reset_pin_active     <= 1'b1;
        end else begin
            low_volt_prog_enable <= lv_prog_en;
            reset_pin_active     <= lv_prog_en | reset_pin_enable;
        end
    end

endmodule : nvm_protection_config
`default_nettype wire

// ---- bench/nvm_prot_chk.sv ----
// Purpose : assertions on the protection configuration ports
// Assumes : bound into nvm_protection_config, one clock domain
// Notes   : decoded outputs trail the stored bits by one cycle
`timescale 1ns/1ps
`default_nettype none
`include "nvm_protection_regs.svh"
module nvm_prot_chk #(
    parameter int PROG_WORDS_LOG2 = `PROG_WORDS_LOG2_DEF  // log2 of user program words
) (
    input wire logic                          clk,
    input wire logic                          srst,
    input wire logic                          cfg_wr,
    input wire logic                          cfg_rd,
    input wire nvm_protection_pkg::cfg_addr_t cfg_addr,
    input wire nvm_protection_pkg::cfg_byte_t cfg_wdata,
    input wire logic                          bulk_erase,
    input wire logic                          lv_prog_active,
    input wire logic                          reset_pin_enable,
    input wire logic                          cfg_wr_refused,
    input wire logic                          cfg_rvalid,
    input wire logic                          boot_block_enable_n,
    input wire logic [2:0]                    boot_block_size_sel,
    input wire logic [15:0]                   boot_block_words,
    input wire logic                          app_block_write_protect_n,
    input wire logic                          low_volt_prog_enable,
    input wire logic                          reset_pin_active
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (srst);
    // largest block allowed: half of the user program memory
    localparam logic [15:0] max_words = 16'h1 << (PROG_WORDS_LOG2 - 1);

    read_valid_a: assert property (cfg_rvalid == $past(cfg_rd))
        else $error("read valid does not track the read strobe");
    // a protect bit may only return to 1 through erase or reset
    sticky_app_a: assert property ($rose(app_block_write_protect_n) |->
        $past(bulk_erase, 2) || $past(srst) || $past(srst, 2))
        else $error("application protect released without erase");
    size_hold_a: assert property (!boot_block_enable_n && !$past(boot_block_enable_n) |->
        $stable(boot_block_size_sel))
        else $error("size code changed while boot block enabled");
    bb_off_a: assert property (boot_block_enable_n |-> boot_block_words == 16'h0)
        else $error("disabled boot block has nonzero size");
    bb_size_a: assert property (!boot_block_enable_n |-> boot_block_words >= 16'h0200 &&
        boot_block_words <= max_words && (boot_block_words & (boot_block_words - 16'h1)) == 16'h0)
        else $error("boot block size outside decode range");
    pin_func_a: assert property (reset_pin_active ==
        (low_volt_prog_enable || $past(reset_pin_enable)))
        else $error("reset pin function wrong");
    lvp_lock_a: assert property (cfg_wr && !bulk_erase && lv_prog_active &&
        cfg_addr == `CFG_WORD_HIGH_ADDR && !cfg_wdata[`HIGH_LV_PROG_BIT] |=> cfg_wr_refused)
        else $error("low voltage clear was not refused");
    erase_blank_a: assert property (bulk_erase |-> ##2 app_block_write_protect_n &&
        boot_block_enable_n && low_volt_prog_enable)
        else $error("erase did not restore blank state");
endmodule : nvm_prot_chk
bind nvm_protection_config nvm_prot_chk #(.PROG_WORDS_LOG2(PROG_WORDS_LOG2)) chk_u (
    .clk(clk), .srst(srst), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr),
    .cfg_wdata(cfg_wdata), .bulk_erase(bulk_erase), .lv_prog_active(lv_prog_active),
    .reset_pin_enable(reset_pin_enable), .cfg_wr_refused(cfg_wr_refused),
    .cfg_rvalid(cfg_rvalid), .boot_block_enable_n(boot_block_enable_n),
    .boot_block_size_sel(boot_block_size_sel), .boot_block_words(boot_block_words),
    .app_block_write_protect_n(app_block_write_protect_n),
    .low_volt_prog_enable(low_volt_prog_enable), .reset_pin_active(reset_pin_active));
`default_nettype wire

// ---- bench/prog_model.sv ----
// Purpose : programmer model driving the configuration access port
// Assumes : one access at a time, strobes last one cycle
// Notes   : released address and data are inverted so no stale value lingers
`timescale 1ns/1ps
`default_nettype none
module prog_model (
    input  wire logic                          clk,
    input  wire logic                          cfg_rvalid,
    input  wire nvm_protection_pkg::cfg_byte_t cfg_rdata,
    input  wire logic                          cfg_wr_refused,
    output logic                               cfg_wr,
    output logic                               cfg_rd,
    output nvm_protection_pkg::cfg_addr_t      cfg_addr,
    output nvm_protection_pkg::cfg_byte_t      cfg_wdata,
    output logic                               cfg_self_write,
    output logic                               bulk_erase
);
    import nvm_protection_pkg::*;
    // idle port at time zero
    initial begin
        cfg_wr = 1'b0;
        cfg_rd = 1'b0;
        bulk_erase = 1'b0;
        cfg_self_write = 1'b0;
        cfg_addr = '0;
        cfg_wdata = '0;
    end
    // qualifiers stand through the sampling edge, answer taken mid-cycle after it
    task automatic access(input logic w, input logic r, input logic e, input cfg_addr_t a,
                          input cfg_byte_t d, input logic s,
                          output logic rf, output logic v, output cfg_byte_t q);
        @(posedge clk);
        cfg_wr <= w;
        cfg_rd <= r;
        bulk_erase <= e;
        cfg_addr <= a;
        cfg_wdata <= d;
        cfg_self_write <= s;
        @(posedge clk);
        cfg_wr <= 1'b0;
        cfg_rd <= 1'b0;
        bulk_erase <= 1'b0;
        cfg_addr <= ~a;
        cfg_wdata <= ~d;
        cfg_self_write <= ~s;
        // registered answers launch at the strobe edge; look once they settle
        @(negedge clk);
        rf = cfg_wr_refused;  // a locked write never lands; a refused LV clear lands its other bits
        v = cfg_rvalid;
        q = cfg_rdata;
    endtask : access
endmodule : prog_model
`default_nettype wire

// ---- bench/tb.sv ----
// Purpose : self-checking bench for the protection configuration block
// Assumes : default parameters, storage area and eeprom fitted
// Notes   : a model of both stored words predicts every result
`timescale 1ns/1ps
`default_nettype none
`include "nvm_protection_regs.svh"
module tb;
    import nvm_protection_pkg::*;
    logic        clk = 1'b0;
    logic        srst = 1'b1;
    logic        lv = 1'b0;   // low voltage interface in use
    logic        rpe = 1'b0;  // reset pin setting
    logic        cfg_wr, cfg_rd, cfg_self_write, bulk_erase, cfg_rvalid, cfg_wr_refused;
    cfg_addr_t   cfg_addr;
    cfg_byte_t   cfg_wdata, cfg_rdata;
    logic        bb_en_n, sa_en_n, app_wp_n, sa_wp_n, ee_wp_n, cf_wp_n, bb_wp_n, lv_en, rpa;
    logic [2:0]  bb_size;
    logic [15:0] bb_words, bb_last;
    logic [7:0]  lo = 8'hFF, hi = 8'hFF;  // model of the two words
    int          error_cnt = 0, tests_run = 0, m_ref = 0, a = 0;

    always #25 clk = ~clk;
    nvm_protection_config dut_u (
        .clk(clk), .srst(srst), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr),
        .cfg_wdata(cfg_wdata), .cfg_self_write(cfg_self_write), .bulk_erase(bulk_erase),
        .lv_prog_active(lv), .reset_pin_enable(rpe), .cfg_rdata(cfg_rdata),
        .cfg_rvalid(cfg_rvalid), .cfg_wr_refused(cfg_wr_refused),
        .boot_block_enable_n(bb_en_n), .boot_block_size_sel(bb_size),
        .boot_block_words(bb_words), .boot_block_last_addr(bb_last),
        .storage_area_enable_n(sa_en_n), .app_block_write_protect_n(app_wp_n),
        .storage_area_write_protect_n(sa_wp_n), .eeprom_write_protect_n(ee_wp_n),
        .config_write_protect_n(cf_wp_n), .boot_block_write_protect_n(bb_wp_n),
        .low_volt_prog_enable(lv_en), .reset_pin_active(rpa));
    prog_model pm_u (.clk(clk), .cfg_rvalid(cfg_rvalid), .cfg_rdata(cfg_rdata),
        .cfg_wr_refused(cfg_wr_refused), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr),
        .cfg_wdata(cfg_wdata), .cfg_self_write(cfg_self_write), .bulk_erase(bulk_erase));

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : finish_test
    // model write: bits only clear, size frozen once the block is enabled
    task automatic m_wr(input int d, input bit s);
        logic [7:0] n;
        m_ref = 0;
        if (s && !hi[1]) begin
            m_ref = 1;
        end else if (a == 0) begin
            n = (lo & 8'(d)) | 8'h60;
            n[2:0] = lo[3] ? 3'(d) : lo[2:0];
            lo = n;
        end else if (a == 1) begin
            n = (hi & 8'(d)) | 8'hD0;
            if (lv && !d[5]) begin
                n[5] = hi[5];
                m_ref = 1;
            end
            hi = n;
        end
    endtask : m_wr
    task automatic chk_out();
        int w;
        w = lo[3] ? 0 : 1 << ((16 - lo[2:0]) > `PROG_WORDS_LOG2_DEF - 1 ?
            `PROG_WORDS_LOG2_DEF - 1 : 16 - lo[2:0]);
        check(bb_en_n, lo[3]);
        check(bb_size, lo[2:0]);
        check(bb_words, 16'(w));
        check(bb_last, 16'(w == 0 ? 0 : w - 1));
        check(sa_en_n, lo[4]);
        check(app_wp_n, lo[7]);
        check(sa_wp_n, hi[3] | lo[4]);
        check(ee_wp_n, hi[2]);
        check(cf_wp_n, hi[1]);
        check(bb_wp_n, hi[0] | lo[3]);
        check(lv_en, hi[5]);
        check(rpa, hi[5] | rpe);
    endtask : chk_out
    // one access through the programmer, then every result compared
    task automatic op(input bit w, input bit r, input bit e, input int d, input bit s);
        logic rf, v;
        cfg_byte_t q, x;
        x = a == 0 ? lo : (a == 1 ? hi : 8'hFF);
        pm_u.access(w, r, e, cfg_addr_t'(`CFG_WORD_LOW_ADDR + a), 8'(d), s, rf, v, q);
        if (e) begin
            lo = 8'hFF;
            hi = 8'hFF;
        end else if (w) begin
            m_wr(d, s);
        end
        check(rf, w && !e && m_ref != 0);
        check(v, r);
        if (r) check(q, x);
        // decoded outputs move one edge after the store; look once settled
        @(negedge clk);
        chk_out();
        @(posedge clk);
    endtask : op

    initial begin
        #3000000;
        error_cnt++;
        finish_test();
    end
    initial begin
        void'($urandom(58581));
        repeat (20) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        @(negedge clk);
        chk_out();
        for (a = 0; a < 3; a++) op(0, 1, 0, 0, 0);
        $display("test blank done");
        a = 0;
        for (int s = 0; s < 8; s++) begin
            op(0, 0, 1, 0, 0);
            op(1, 0, 0, 'hF0 | s, 0);
        end
        op(1, 0, 0, 8'hF2, 0);
        $display("test boot block done");
        a = 1;
        lv <= 1'b1;
        op(1, 0, 0, 8'hDF, 0);
        lv <= 1'b0;
        op(1, 0, 0, 8'hDF, 0);
        op(1, 0, 0, 8'hFF, 0);
        op(1, 0, 0, 8'hFD, 0);
        a = 0;
        op(1, 0, 0, 8'h00, 1);
        $display("test locks done");
        for (int i = 0; i < 80; i++) begin
            a = $urandom % 3;
            lv <= 1'($urandom);
            rpe <= 1'($urandom);
            op(1, 0, $urandom % 8 == 0, $urandom | $urandom, a < 2 && $urandom % 4 == 0);
            op(0, 1, 0, 0, 0);
        end
        $display("test random done");
        srst <= 1'b1;
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        lo = 8'hFF;
        hi = 8'hFF;
        @(posedge clk);
        @(negedge clk);
        chk_out();
        $display("test reset done");
        finish_test();
    end
endmodule : tb
`default_nettype wire
